// file: rtl/serial_frame_transceiver_regs.vh
// register map, field positions and constants of the serial frame transceiver
// Contract
// - frame opens with one start bit, then data
// - parity sits after data, before first stop
// - next start may follow stop bits directly
// - accept 5-9 data bits, any parity, 1-2 stops
// - start bit is always driven low
// - stop bits and idle line are high
// - one-entry transmit buffer before shift register
// - two-entry receive buffer keeps status flags
// - buffering allows gapless back-to-back frames
// - output enables external RS-485 line driver
// - one-wire mode uses transmit pin both ways
// - transfer clock pin driven or received
// - bit clock from baud generator or pin
// - open drain forces transmit pin to output; here the pin is enabled only while it drives low, and is released for high
// - loopback feeds transmit line into receiver
// - generate and check odd or even parity
// - overflow and framing errors stored with frame
// - reject false starts, low-pass filter input
// - separate tx complete, empty, rx complete sources
// - divisor holds factor shifted six, 64..65535
// - samples per bit 16, 8 or 2
`ifndef SERIAL_FRAME_TRANSCEIVER_REGS_VH
`define SERIAL_FRAME_TRANSCEIVER_REGS_VH
// ==========================================
// register byte offsets
`define SFT_DATA_OFS 5'h00
`define SFT_STATUS_OFS 5'h04
`define SFT_CTRL_OFS 5'h08
`define SFT_FORMAT_OFS 5'h0c
`define SFT_BAUD_OFS 5'h10
// ==========================================
// data word fields
`define SFT_PERR_BIT 12
`define SFT_FERR_BIT 13
`define SFT_BUFOVF_BIT 14
// status fields
`define SFT_RXC_BIT 0
`define SFT_DRE_BIT 1
`define SFT_TXC_BIT 2
// control fields
`define SFT_TXEN_BIT 0
`define SFT_RXEN_BIT 1
`define SFT_LOOP_BIT 2
`define SFT_ODRAIN_BIT 3
`define SFT_DBL_BIT 4
`define SFT_SYNC_BIT 5
`define SFT_CLKMST_BIT 6
`define SFT_RS485_BIT 7
// format fields: size code, parity, stop count
`define SFT_PAR_NONE 2'h0
`define SFT_PAR_EVEN 2'h2
`define SFT_PAR_ODD 2'h3
// ==========================================
// reset values
`define SFT_CTRL_RST 8'h00
`define SFT_FORMAT_RST 7'h03
`define SFT_BAUD_RST 16'h0040
// samples per bit and divisor step
`define SFT_S_NORMAL 5'h10
`define SFT_S_DOUBLE 5'h08
`define SFT_S_SYNC 5'h02
`define SFT_FRAC_STEP 17'h00040
`endif

// file: rtl/serial_frame_transceiver.v
// serial frame transceiver with wishbone register slave
`include "serial_frame_transceiver_regs.vh"

module serial_frame_transceiver
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // wishbone classic slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [4:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // transmit pin, two-way
  input wire txdIn,
  output reg txdOut,
  output reg txdOe_n,
  // receive pin
  input wire rxdIn,
  // transfer clock pin, two-way
  input wire xckIn,
  output reg xckOut,
  output reg xckOe_n,
  // rs-485 driver enable
  output reg lineDriverEnable,
  // event sources, levels
  output reg txCompleteIrq,
  output reg dataEmptyIrq,
  output reg rxCompleteIrq
);

  // ==========================================
  // helpers
  // data mask for a size code, codes 4 and above mean nine bits
  function [8:0] dataMask;
    input [2:0] code;
    begin
      case (code)
        3'h0: dataMask = 9'h01f;
        3'h1: dataMask = 9'h03f;
        3'h2: dataMask = 9'h07f;
        3'h3: dataMask = 9'h0ff;
        default: dataMask = 9'h1ff;
      endcase
    end
  endfunction

  // number of data bits for a size code
  function [3:0] dataCount;
    input [2:0] code;
    begin
      dataCount = (code > 3'h4) ? 4'h9 : ({1'b0, code} + 4'h5);
    end
  endfunction

  // parity bit: even makes total ones even
  function parityOf;
    input [8:0] d;
    input odd;
    begin
      parityOf = (^d) ^ odd;
    end
  endfunction

  // ==========================================
  // registers
  reg [7:0] ctrl;
  reg [6:0] format;
  reg [15:0] baud;
  reg txcFlag;

  wire txEn = ctrl[`SFT_TXEN_BIT];
  wire rxEn = ctrl[`SFT_RXEN_BIT];
  wire loopEn = ctrl[`SFT_LOOP_BIT];
  wire odEn = ctrl[`SFT_ODRAIN_BIT];
  wire syncMode = ctrl[`SFT_SYNC_BIT];
  wire clkMaster = ctrl[`SFT_CLKMST_BIT];
  wire [2:0] sizeCode = format[2:0];
  wire parEn = format[5];
  wire parOdd = format[4];
  wire twoStop = format[6];
  wire [8:0] mask = dataMask(sizeCode);
  wire [3:0] nData = dataCount(sizeCode);

  // bus access taken at the edge where ack is raised
  wire busGo = cyc_i & stb_i & ~ack_o;
  wire busWr = busGo & we_i;
  wire busRd = busGo & ~we_i;
  wire dataWr = busWr & (adr_i == `SFT_DATA_OFS) & sel_i[0];
  wire dataRd = busRd & (adr_i == `SFT_DATA_OFS);

  // ==========================================
  // pin synchronisers
  reg rxdS1, rxdS2, txdS1, txdS2, xckS1, xckS2, xckPrev;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      {rxdS1, rxdS2, txdS1, txdS2} <= 4'hf;
      {xckS1, xckS2, xckPrev} <= 3'h0;
    end
    else
    begin
      rxdS1 <= rxdIn;
      rxdS2 <= rxdS1;
      txdS1 <= txdIn;
      txdS2 <= txdS1;
      xckS1 <= xckIn;
      xckS2 <= xckS1;
      xckPrev <= clkMaster ? xckOut : xckS2;
    end
  end

  // ==========================================
  // fractional baud generator
  // divisor is factor times 64, so adding 64 per clock gives the fraction
  reg [16:0] fracAcc;
  reg tick;
  wire [16:0] divisor = syncMode ? {1'b0, baud[15:6], 6'h00} : {1'b0, baud};
  wire [16:0] accNext = fracAcc + `SFT_FRAC_STEP;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      fracAcc <= 17'h00000;
      tick <= 1'b0;
    end
    else if (accNext >= divisor)
    begin
      fracAcc <= accNext - divisor;
      tick <= 1'b1;
    end
    else
    begin
      fracAcc <= accNext;
      tick <= 1'b0;
    end
  end

  // samples per bit for the current mode
  wire [4:0] spb = syncMode ? `SFT_S_SYNC : (ctrl[`SFT_DBL_BIT] ? `SFT_S_DOUBLE : `SFT_S_NORMAL);

  // transfer clock: master toggles per tick, slave follows the pin
  wire xckLevel = clkMaster ? xckOut : xckS2;
  wire xckRise = syncMode & xckLevel & ~xckPrev;
  wire xckFall = syncMode & ~xckLevel & xckPrev;

  // ==========================================
  // transmitter
  reg [8:0] txBuf;
  reg txFull;
  reg [12:0] txShift;
  reg [3:0] txLeft;
  reg txBusy;
  reg [4:0] txCnt;
  reg txLine;

  // bit boundary: tx changes on falling transfer clock in sync mode
  wire txStep = syncMode ? xckFall : (tick & (txCnt == spb - 5'h01));
  wire txLoad = txFull & txEn & (~txBusy | (txStep & (txLeft == 4'h1)));
  wire txDone = txBusy & txStep & (txLeft == 4'h1);
  wire [8:0] txData = txBuf & mask;
  wire txPar = parityOf(txData, parOdd);
  // frame laid out lsb first: start, data, parity, stops
  reg [12:0] txFrame;
  reg [3:0] txLen;
  always @*
  begin
    txFrame = 13'h1fff;
    txFrame[0] = 1'b0;
    txFrame[9:1] = txData | ~mask;
    txFrame[nData + 4'h1] = parEn ? txPar : 1'b1;
    txLen = 4'h2 + nData + {3'h0, parEn} + {3'h0, twoStop};
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      txBuf <= 9'h000;
      txFull <= 1'b0;
      txShift <= 13'h1fff;
      txLeft <= 4'h0;
      txBusy <= 1'b0;
      txCnt <= 5'h00;
      txLine <= 1'b1;
    end
    else
    begin
      // single-entry buffer, writes while full are ignored
      if (dataWr & ~txFull)
      begin
        txBuf <= {sel_i[1] & dat_i[8], dat_i[7:0]};
        txFull <= 1'b1;
      end
      else if (txLoad)
        txFull <= 1'b0;
      if (~syncMode & txBusy & tick)
        txCnt <= (txCnt == spb - 5'h01) ? 5'h00 : txCnt + 5'h01;
      // reload at the last boundary so frames abut with no idle gap
      if (txLoad)
      begin
        txShift <= {1'b1, txFrame[12:1]};
        txLine <= txFrame[0];
        txLeft <= txLen;
        txBusy <= 1'b1;
        txCnt <= 5'h00;
      end
      else if (txDone)
      begin
        txBusy <= 1'b0;
        txLine <= 1'b1;
      end
      else if (txBusy & txStep)
      begin
        txLine <= txShift[0];
        txShift <= {1'b1, txShift[12:1]};
        txLeft <= txLeft - 4'h1;
      end
    end
  end

  // ==========================================
  // receiver front end
  // loopback reads the shared pin, ANDed with own line for one-wire
  wire rxPin = loopEn ? (txdS2 & txLine) : rxdS2;
  reg [2:0] rxHist;
  wire rxMaj = (rxHist[0] & rxHist[1]) | (rxHist[1] & rxHist[2]) | (rxHist[0] & rxHist[2]);
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_BITS = 2'h2;
  reg [1:0] rxState;
  reg [4:0] rxCnt;
  reg [3:0] rxIdx;
  reg [10:0] rxBits;
  reg rxDone;

  // sample point: middle of bit after three filter samples
  wire rxMid = tick & (rxCnt == {1'b0, spb[4:1]});
  wire rxSample = syncMode ? xckRise : rxMid;
  wire rxBit = syncMode ? rxPin : rxMaj;
  wire [3:0] rxLast = nData + {3'h0, parEn};

  always @(posedge clk)
  begin
    if (sys_rst | ~rxEn)
    begin
      rxHist <= 3'h7;
      rxState <= RX_IDLE;
      rxCnt <= 5'h00;
      rxIdx <= 4'h0;
      rxBits <= 11'h000;
      rxDone <= 1'b0;
    end
    else
    begin
      rxDone <= 1'b0;
      if (tick)
      begin
        rxHist <= {rxHist[1:0], rxPin};
        rxCnt <= (rxCnt == spb - 5'h01) ? 5'h00 : rxCnt + 5'h01;
      end
      case (rxState)
        RX_IDLE:
          if (syncMode ? (xckRise & ~rxPin) : (tick & ~rxPin))
          begin
            rxState <= syncMode ? RX_BITS : RX_START;
            rxCnt <= 5'h01;
            rxIdx <= 4'h0;
          end
        RX_START:
          if (rxMid)
            rxState <= rxMaj ? RX_IDLE : RX_BITS;
        RX_BITS:
          if (rxSample)
          begin
            rxBits[rxIdx] <= rxBit;
            rxIdx <= rxIdx + 4'h1;
            // only the first stop is checked, a second one is ignored
            if (rxIdx == rxLast)
            begin
              rxState <= RX_IDLE;
              rxDone <= 1'b1;
            end
          end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // ==========================================
  // two-entry receive buffer with flags per frame
  reg [11:0] rxMem [0:1];
  reg rxWp, rxRp;
  reg [1:0] rxCount;
  wire [8:0] rxData = rxBits[8:0] & mask;
  wire rxStop = rxBits[rxLast];
  wire rxParBit = rxBits[nData];
  wire rxPerr = parEn & (rxParBit != parityOf(rxData, parOdd));
  wire rxPop = dataRd & (rxCount != 2'h0);
  wire rxOvf = rxDone & (rxCount == 2'h2) & ~rxPop;
  wire [11:0] rxEntry = {rxOvf, ~rxStop, rxPerr, rxData};

  always @(posedge clk)
  begin
    if (sys_rst | ~rxEn)
    begin
      rxMem[0] <= 12'h000;
      rxMem[1] <= 12'h000;
      rxWp <= 1'b0;
      rxRp <= 1'b0;
      rxCount <= 2'h0;
    end
    else
    begin
      if (rxPop)
        rxRp <= ~rxRp;
      // when full the newest entry is overwritten and marked
      if (rxOvf)
        rxMem[~rxWp] <= rxEntry;
      else if (rxDone)
      begin
        rxMem[rxWp] <= rxEntry;
        rxWp <= ~rxWp;
      end
      if ((rxDone & ~rxOvf) & ~rxPop)
        rxCount <= rxCount + 2'h1;
      else if (~(rxDone & ~rxOvf) & rxPop)
        rxCount <= rxCount - 2'h1;
    end
  end

  // ==========================================
  // register writes and sticky transmit-complete flag
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl <= `SFT_CTRL_RST;
      format <= `SFT_FORMAT_RST;
      baud <= `SFT_BAUD_RST;
      txcFlag <= 1'b0;
    end
    else
    begin
      if (busWr & sel_i[0] & (adr_i == `SFT_CTRL_OFS))
        ctrl <= dat_i[7:0];
      if (busWr & sel_i[0] & (adr_i == `SFT_FORMAT_OFS))
        format <= dat_i[6:0];
      if (busWr & (adr_i == `SFT_BAUD_OFS))
      begin
        if (sel_i[0])
          baud[7:0] <= dat_i[7:0];
        if (sel_i[1])
          baud[15:8] <= dat_i[15:8];
      end
      // completion with nothing buffered sets, set beats clear
      if (txDone & ~txLoad)
        txcFlag <= 1'b1;
      else if (busWr & sel_i[0] & (adr_i == `SFT_STATUS_OFS) & dat_i[`SFT_TXC_BIT])
        txcFlag <= 1'b0;
    end
  end

  // ==========================================
  // bus answer: one-cycle ack, unmapped reads return zero
  reg [31:0] rdMux;
  always @*
  begin
    rdMux = 32'h00000000;
    case (adr_i)
      `SFT_DATA_OFS: rdMux = (rxCount != 2'h0) ? {17'h00000, rxMem[rxRp][11:9], 3'h0, rxMem[rxRp][8:0]} : 32'h0;
      `SFT_STATUS_OFS:
      begin
        rdMux[`SFT_RXC_BIT] = rxCount != 2'h0;
        rdMux[`SFT_DRE_BIT] = ~txFull;
        rdMux[`SFT_TXC_BIT] = txcFlag;
      end
      `SFT_CTRL_OFS: rdMux = {24'h000000, ctrl};
      `SFT_FORMAT_OFS: rdMux = {25'h0000000, format};
      `SFT_BAUD_OFS: rdMux = {16'h0000, baud};
      default: rdMux = 32'h00000000;
    endcase
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= busGo;
      dat_o <= busRd ? rdMux : 32'h00000000;
    end
  end

  // ==========================================
  // pin drivers and event outputs
  // transmitter keeps the pin until its buffer and shifter drain
  wire txOwn = txEn | txBusy | txFull;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      txdOut <= 1'b1;
      txdOe_n <= 1'b1;
      xckOut <= 1'b0;
      xckOe_n <= 1'b1;
      lineDriverEnable <= 1'b0;
      txCompleteIrq <= 1'b0;
      dataEmptyIrq <= 1'b0;
      rxCompleteIrq <= 1'b0;
    end
    else
    begin
      txdOut <= txLine;
      // open drain pulls low only, the pull-up makes the high level
      if (odEn)
        txdOe_n <= ~(txOwn & ~txLine);
      else
        txdOe_n <= ~txOwn;
      if (syncMode & clkMaster & (txEn | rxEn) & tick)
        xckOut <= ~xckOut;
      else if (~(syncMode & clkMaster))
        xckOut <= 1'b0;
      xckOe_n <= ~(syncMode & clkMaster);
      lineDriverEnable <= ctrl[`SFT_RS485_BIT] & (txBusy | txLoad);
      txCompleteIrq <= txcFlag;
      dataEmptyIrq <= ~txFull & txEn;
      rxCompleteIrq <= rxCount != 2'h0;
    end
  end

endmodule

// file: testbench/serial_frame_transceiver_asserts.sv
// port checker for the serial frame transceiver
module serial_frame_transceiver_asserts
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // register bus
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  // line side
  input wire txdOut,
  input wire txdOe_n,
  input wire xckOe_n,
  input wire lineDriverEnable,
  input wire txCompleteIrq,
  input wire dataEmptyIrq,
  input wire rxCompleteIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // bus answers
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // a held strobe must still see ack fall, or the master double-writes
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  read_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  // ==========
  // line levels and framing
  reset_idle_a: assert property ($fell(sys_rst) |-> txdOut && txdOe_n && xckOe_n && !lineDriverEnable)
    else $error("line not idle after reset");
  // shortest asynchronous bit is eight cycles, double speed at the minimum divisor
  start_low_a: assert property ($fell(txdOut) |-> !txdOut [*8])
    else $error("low bit too short");
  driver_frame_a: assert property ($rose(lineDriverEnable) |-> ##[0:3] !txdOut)
    else $error("driver enable without start bit");
  stop_high_a: assert property ($rose(txCompleteIrq) |-> txdOut)
    else $error("complete while line low");
  buffer_fill_a: assert property ($fell(dataEmptyIrq) |-> $past(we_i) || $past(we_i, 2) || $past(we_i, 3))
    else $error("buffer filled without a write");
  // ==========
  // scenarios reached
  cover property ($fell(txdOut));
  cover property ($rose(rxCompleteIrq));
  cover property ($rose(lineDriverEnable));
endmodule

bind serial_frame_transceiver serial_frame_transceiver_asserts serial_frame_transceiver_asserts_inst (.clk, .sys_rst,
  .cyc_i, .stb_i, .we_i, .dat_o, .ack_o, .txdOut, .txdOe_n, .xckOe_n, .lineDriverEnable, .txCompleteIrq,
  .dataEmptyIrq, .rxCompleteIrq);

// file: testbench/serial_peer.sv
// remote serial peer: frame sender and line receiver
module serial_peer
(
  // clock
  input wire clk,
  // line from and to the transceiver
  input wire lineIn,
  output logic lineOut
);
  timeunit 1ns;
  timeprecision 1ps;
  int spb = 16;
  // ==========
  // idle line is high between frames
  initial lineOut = 1'b1;
  task automatic hold(input logic b);
    lineOut <= b;
    repeat (spb) @(posedge clk);
  endtask
  // one frame; bad parity or a low stop only on request
  task automatic send(input logic [8:0] d, input int nb, input logic [1:0] par, input int st, input logic bp,
    input logic bs);
    logic p;
    p = ^(d & ((9'h1 << nb) - 9'h1)) ^ par[0] ^ bp;
    hold(1'b0);
    for (int i = 0; i < nb; i++) hold(d[i]);
    if (par[1]) hold(p);
    // a bad stop is low only up to mid-bit, so no false start follows it
    if (bs)
    begin
      lineOut <= 1'b0;
      repeat (spb / 2) @(posedge clk);
      lineOut <= 1'b1;
      repeat (spb - spb / 2) @(posedge clk);
    end
    else
      hold(1'b1);
    if (st == 2) hold(1'b1);
    lineOut <= 1'b1;
  endtask
  // short low pulse, shorter than half a bit
  task automatic glitch(input int n);
    lineOut <= 1'b0;
    repeat (n) @(posedge clk);
    lineOut <= 1'b1;
  endtask
  // ==========
  // receive one frame, sampling mid-bit
  task automatic recv(input int nb, input logic [1:0] par, input int st, output logic [8:0] d, output logic p,
    output logic s, output time t);
    int n;
    n = 0;
    d = 9'h0;
    p = 1'b0;
    s = 1'b1;
    while (lineIn !== 1'b0 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    t = $time;
    repeat (spb / 2) @(posedge clk);
    for (int i = 0; i < nb; i++)
    begin
      repeat (spb) @(posedge clk);
      d[i] = lineIn;
    end
    if (par[1])
    begin
      repeat (spb) @(posedge clk);
      p = lineIn;
    end
    for (int k = 0; k < st; k++)
    begin
      repeat (spb) @(posedge clk);
      s = s & lineIn;
    end
  endtask
endmodule

// file: testbench/test_serial_frame_transceiver.sv
// self-checking bench for the serial frame transceiver
`include "serial_frame_transceiver_regs.vh"
`define CHK(s,e,a) begin nChecks++; if((a)!==(e)) begin miscompares++; $display("unexpected %s exp %h saw %h",s,e,a); end end
module test_serial_frame_transceiver;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, q;
  logic [8:0] g0, g1;
  logic pp, ss;
  time t0, t1;
  int miscompares = 0, nChecks = 0, k = 0;
  wire [31:0] rdat;
  wire ack, txO, txOe, xckOe, xckO, lde, txcI, dreI, rxcI, peerLine, pin;
  // ==========
  // pin with pull-up: released or open-drain high reads 1
  assign pin = txOe ? 1'b1 : txO;
  serial_frame_transceiver serial_frame_transceiver_inst (.clk(clk), .sys_rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .txdIn(pin), .txdOut(txO),
    .txdOe_n(txOe), .rxdIn(peerLine), .xckIn(1'b0), .xckOut(xckO), .xckOe_n(xckOe), .lineDriverEnable(lde),
    .txCompleteIrq(txcI), .dataEmptyIrq(dreI), .rxCompleteIrq(rxcI));
  serial_peer serial_peer_inst (.clk(clk), .lineIn(pin), .lineOut(peerLine));
  // 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // verdict, shared by the main sequence and the watchdog
  task automatic results();
    if (miscompares == 0 && nChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========
  // one wishbone classic cycle; waits for ack, no fixed latency assumed
  task automatic wb(input logic [4:0] a, input logic [31:0] d, input logic w);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    if (n >= 50) miscompares++;
  endtask
  // send d out, then take ~d in (or own echo in one-wire)
  task automatic txChk(input int nb, input logic [1:0] par, input int st, input logic [8:0] d, input logic echo);
    logic [8:0] mk, g;
    logic p, s;
    time t;
    mk = (9'h1 << nb) - 9'h1;
    fork
      serial_peer_inst.recv(nb, par, st, g, p, s, t);
      wb(`SFT_DATA_OFS, {23'h0, d}, 1'b1);
    join
    `CHK("txdata", d & mk, g)
    if (par[1]) `CHK("txparity", ^(d & mk) ^ par[0], p)
    `CHK("txstop", 1'b1, s)
    serial_peer_inst.send(~d, nb, par, st, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    wb(`SFT_DATA_OFS, 32'h0, 1'b0);
    `CHK("rxdata", {23'h0, (echo ? d : ~d) & mk}, q)
  endtask
  // ==========
  // watchdog
  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    results();
  end
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(`SFT_FORMAT_OFS, 32'h0, 1'b0);
    `CHK("format", 32'h3, q)
    wb(`SFT_BAUD_OFS, 32'h0, 1'b0);
    `CHK("baud", 32'h40, q)
    wb(5'h14, 32'h0, 1'b0);
    `CHK("unmapped", 32'h0, q)
    wb(`SFT_BAUD_OFS, 32'h40, 1'b1);
    wb(`SFT_CTRL_OFS, 32'h3, 1'b1);
    `CHK("dreempty", 1'b1, dreI)
    // every size, parity and stop count
    for (int nb = 5; nb <= 9; nb++)
      for (int pi = 0; pi < 3; pi++)
        for (int st = 1; st <= 2; st++)
        begin
          wb(`SFT_FORMAT_OFS, 32'(((st - 1) << 6) | ((pi == 0 ? 0 : pi + 1) << 4) | (nb - 5)), 1'b1);
          txChk(nb, (pi == 0) ? 2'h0 : 2'(pi + 1), st, 9'h0b3 + 9'(k * 37), 1'b0);
          k++;
        end
    // back-to-back frames leave no gap between stop and next start
    wb(`SFT_FORMAT_OFS, 32'h3, 1'b1);
    wb(`SFT_STATUS_OFS, 32'h4, 1'b1);
    `CHK("txpre", 1'b0, txcI)
    fork
      begin
        serial_peer_inst.recv(8, 2'h0, 1, g0, pp, ss, t0);
        serial_peer_inst.recv(8, 2'h0, 1, g1, pp, ss, t1);
      end
      begin
        wb(`SFT_DATA_OFS, 32'h41, 1'b1);
        wb(`SFT_DATA_OFS, 32'h42, 1'b1);
      end
    join
    `CHK("gap", 64'd1600, t1 - t0)
    `CHK("second", 9'h042, g1)
    repeat (20) @(posedge clk);
    `CHK("txdone", 1'b1, txcI)
    wb(`SFT_STATUS_OFS, 32'h4, 1'b1);
    repeat (3) @(posedge clk);
    `CHK("txclear", 1'b0, txcI)
    // parity error, framing error, then overflow of the two-entry buffer
    wb(`SFT_FORMAT_OFS, 32'h23, 1'b1);
    serial_peer_inst.send(9'h03c, 8, 2'h2, 1, 1'b1, 1'b0);
    repeat (32) @(posedge clk);
    serial_peer_inst.send(9'h05a, 8, 2'h2, 1, 1'b0, 1'b1);
    repeat (32) @(posedge clk);
    serial_peer_inst.send(9'h011, 8, 2'h2, 1, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    `CHK("rxready", 1'b1, rxcI)
    wb(`SFT_DATA_OFS, 32'h0, 1'b0);
    `CHK("perr", 32'h103c, q)
    wb(`SFT_DATA_OFS, 32'h0, 1'b0);
    `CHK("ovf", 32'h4011, q)
    wb(`SFT_DATA_OFS, 32'h0, 1'b0);
    `CHK("empty", 32'h0, q)
    // false start is dropped
    serial_peer_inst.glitch(3);
    repeat (300) @(posedge clk);
    wb(`SFT_STATUS_OFS, 32'h0, 1'b0);
    `CHK("falsestart", 1'b0, q[0])
    // driver enable across a frame
    wb(`SFT_FORMAT_OFS, 32'h3, 1'b1);
    wb(`SFT_CTRL_OFS, 32'h83, 1'b1);
    fork
      serial_peer_inst.recv(8, 2'h0, 1, g0, pp, ss, t0);
      begin
        wb(`SFT_DATA_OFS, 32'h5c, 1'b1);
        repeat (40) @(posedge clk);
        `CHK("drvon", 1'b1, lde)
      end
    join
    repeat (40) @(posedge clk);
    `CHK("drvoff", 1'b0, lde)
    // double speed halves the bit
    wb(`SFT_CTRL_OFS, 32'h13, 1'b1);
    serial_peer_inst.spb = 8;
    txChk(8, 2'h0, 1, 9'h0c3, 1'b0);
    serial_peer_inst.spb = 16;
    // one wire: loopback and open drain before rate, format and enable
    wb(`SFT_CTRL_OFS, 32'h0c, 1'b1);
    wb(`SFT_BAUD_OFS, 32'h40, 1'b1);
    wb(`SFT_FORMAT_OFS, 32'h3, 1'b1);
    wb(`SFT_CTRL_OFS, 32'h0f, 1'b1);
    txChk(8, 2'h0, 1, 9'h096, 1'b1);
    // sync master drives the transfer clock pin
    wb(`SFT_CTRL_OFS, 32'h62, 1'b1);
    repeat (4) @(posedge clk);
    `CHK("xckdrive", 1'b0, xckOe)
    pp = xckO;
    @(posedge clk);
    `CHK("xcktoggle", ~pp, xckO)
    results();
  end
endmodule
